// ---- src/ucf_core.sv ----
// Baud generator, clock selection and frame engine of a sync/async serial port.
// Assumes an Avalon-MM master, a synchronous rxd/xck input and an external pad for xck.
// What this block does
// - Baud down-counter on system clock reloads at zero and on divisor low-byte write.
// - Each zero of the counter gives one tick: rate is clock over divisor+1.
// - Transmitter divides ticks by 16 normal, 8 double speed, 2 sync master.
// - Receiver takes ticks directly with 16 or 8 states per bit; sync takes one sample edge per bit.
// - Divisor is twelve bits, split over high and low registers.
// - Double speed acts only in async mode; hardware masks it off in sync.
// - Double speed receiver uses 8 samples per bit instead of 16.
// - Slave clock passes a sync register and edge detector, two clocks late.
// - In sync mode the clock pin drives as master, listens as slave.
// - Receive samples on the clock edge opposite the transmit change edge.
// - Polarity zero: change on rising, sample on falling; one swaps them.
// - Thirty formats: start, 5 to 9 data, parity none/even/odd, 1-2 stops.
// - Frame order: start, data LSB first, optional parity, stop bits.
// - Start low, stop high, idle high; frames may follow back to back.
// - One shared format setting; changing it corrupts transfers in flight.
// - Receiver checks only first stop bit; frame error when it is zero.
// - Even parity is XOR of data bits; odd parity is its inverse.
// - Three-bit size field, two-bit parity field, one stop-select bit.
// - Internal generator clocks async and sync master; pin clocks sync slave.
// - Mode bit one selects synchronous, zero asynchronous.
// - In sync mode pin direction output means master, input means slave.
// - Parity on when upper parity-mode bit set; sits before first stop.
// - Size seven gives nine-bit characters; ninth bit sent from its own control bit, received into its own status bit.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module ucf_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ucf_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [ucf_pkg::DATA_W-1:0] avs_writedata_i,
	output logic [ucf_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic rxd_i,
	output logic txd_o,
	input wire logic xck_i,
	output logic xck_o,
	output logic xck_oe_n_o
);
	import ucf_pkg::*;

	// Data bits per character from the size field
	function automatic logic [3:0] data_bits(input logic [2:0] cs);
		case (cs)
			3'h0: data_bits = 4'h5;
			3'h1: data_bits = 4'h6;
			3'h2: data_bits = 4'h7;
			CS_NINE: data_bits = 4'h9;
			default: data_bits = 4'h8;
		endcase
	endfunction

	// Parity over the low nb bits, seeded with one for odd
	function automatic logic par_calc(input logic [8:0] d, input logic [3:0] nb,
		input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < CHR_W; i++) begin
			if (i < int'(nb)) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction

	// Bus and register state
	logic ack_q, ack_d;
	logic [DATA_W-1:0] rdat_q, rdat_d;
	logic [DIV_W-1:0] div_q, div_d;
	ucf_cfg_s cfg_q, cfg_d;
	logic [CHR_W-1:0] tbuf_q, tbuf_d;
	logic tfull_q, tfull_d;
	logic txc_q, txc_d;
	logic rxc_q, rxc_d;
	logic wr_acc, rd_acc, lo_wr;
	ucf_stat_s stat;
	// Clock generation state
	logic [DIV_W-1:0] baud_q, baud_d;
	logic [3:0] tp_q, tp_d;
	logic xm_q, xm_d;
	logic xs1_q, xs2_q, xs3_q;
	logic tick, sync, master, slave, u2x, rise, fall, chg_ev, smp_ev;
	logic tx_step, rx_tick;
	logic [3:0] tx_top, rx_top, nb;
	logic par_en, par_odd;
	// Transmit state
	ucf_tx_e tst_q, tst_d;
	logic [CHR_W-1:0] tsh_q, tsh_d;
	logic [3:0] tcnt_q, tcnt_d;
	logic tpar_q, tpar_d;
	logic txd_q, txd_d;
	logic tx_load, tx_done;
	// Receive state
	ucf_rx_e rst_q, rst_d;
	logic [CHR_W-1:0] rsh_q, rsh_d;
	logic [CHR_W-1:0] rxdat_q, rxdat_d;
	logic [3:0] rcnt_q, rcnt_d;
	logic [3:0] roc_q, roc_d;
	logic rpar_q, rpar_d;
	logic fe_q, fe_d;
	logic pe_q, pe_d;
	logic rx_done;

	// Shared format decode for both directions
	assign nb = data_bits(cfg_q.char_size);
	assign par_en = cfg_q.parity_mode[1];
	assign par_odd = cfg_q.parity_mode[0];
	assign sync = cfg_q.sync_mode_select;
	assign master = sync & cfg_q.ext_clock_pin_direction;
	assign slave = sync & ~cfg_q.ext_clock_pin_direction;
	assign u2x = cfg_q.double_speed & ~sync;

	// One wait cycle per request, so read data is always registered
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
	assign wr_acc = avs_write_i & ack_q;
	assign rd_acc = avs_read_i & ack_q;
	assign lo_wr = wr_acc & (avs_address_i == OFS_DIV_LO) & avs_byteenable_i[0];
	assign avs_readdata_o = rdat_q;
	assign stat = '{rx_bit8: rxdat_q[8], parity_error: pe_q, frame_error: fe_q,
		busy: (tst_q != TX_IDLE) | tfull_q, rx_complete_flag: rxc_q,
		tx_complete_flag: txc_q};

	// Register file: reads, writes and flag set/clear
	always_comb begin
		logic [CFG_W-1:0] cv;
		cv = cfg_q;
		ack_d = (avs_read_i | avs_write_i) & ~ack_q;
		rdat_d = rdat_q;
		div_d = div_q;
		tbuf_d = tbuf_q;
		if (avs_read_i & ~ack_q) begin
			case (avs_address_i)
				OFS_DIV_LO: rdat_d = {24'h000000, div_q[7:0]};
				OFS_DIV_HI: rdat_d = {28'h0000000, div_q[11:8]};
				OFS_CTRL: rdat_d = {19'h00000, cfg_q};
				OFS_STAT: rdat_d = {26'h0000000, stat};
				OFS_DATA: rdat_d = {24'h000000, rxdat_q[7:0]};
				default: rdat_d = 32'h00000000;
			endcase
		end
		if (lo_wr) begin
			div_d[7:0] = avs_writedata_i[7:0];
		end
		if (wr_acc & (avs_address_i == OFS_DIV_HI) & avs_byteenable_i[0]) begin
			div_d[11:8] = avs_writedata_i[3:0];
		end
		if (wr_acc & (avs_address_i == OFS_CTRL)) begin
			if (avs_byteenable_i[0]) begin
				cv[7:0] = avs_writedata_i[7:0];
			end
			if (avs_byteenable_i[1]) begin
				cv[12:8] = avs_writedata_i[12:8];
			end
		end
		cfg_d = ucf_cfg_s'(cv);
		// Data write loads the buffer with the ninth bit beside it
		if (wr_acc & (avs_address_i == OFS_DATA) & avs_byteenable_i[0]) begin
			tbuf_d = {cfg_q.tx_bit8, avs_writedata_i[7:0]};
		end
		tfull_d = (tfull_q & ~tx_load) |
			(wr_acc & (avs_address_i == OFS_DATA) & avs_byteenable_i[0]);
		// Hardware set wins over the software clear
		txc_d = tx_done | (txc_q & ~(wr_acc & (avs_address_i == OFS_STAT) &
			avs_byteenable_i[0] & avs_writedata_i[STAT_TXC]));
		rxc_d = rx_done | (rxc_q & ~(rd_acc & (avs_address_i == OFS_DATA)));
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
			div_q <= DIV_RST;
			cfg_q <= ucf_cfg_s'(CFG_RST);
			tbuf_q <= 9'h000;
			tfull_q <= 1'b0;
			txc_q <= 1'b0;
			rxc_q <= 1'b0;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			div_q <= div_d;
			cfg_q <= cfg_d;
			tbuf_q <= tbuf_d;
			tfull_q <= tfull_d;
			txc_q <= txc_d;
			rxc_q <= rxc_d;
		end
	end

	// Edge events: internal toggle as master, synchronised pin as slave
	assign tick = (baud_q == 12'h000);
	assign rise = xs2_q & ~xs3_q;
	assign fall = ~xs2_q & xs3_q;
	assign chg_ev = master ? (tick & (xm_q == cfg_q.clock_polarity)) :
		(cfg_q.clock_polarity ? fall : rise);
	assign smp_ev = master ? (tick & (xm_q != cfg_q.clock_polarity)) :
		(cfg_q.clock_polarity ? rise : fall);
	assign tx_top = u2x ? TOP_DBL : TOP_NORM;
	assign rx_top = sync ? TOP_SYNC : tx_top;
	assign tx_step = sync ? chg_ev : (tick & (tp_q == 4'h0));
	assign rx_tick = sync ? smp_ev : tick;
	assign xck_o = xm_q;
	assign xck_oe_n_o = ~master;

	// Baud counter, transmit prescaler and master clock toggle
	always_comb begin
		if (lo_wr) begin
			baud_d = {div_q[11:8], avs_writedata_i[7:0]};
		end else if (tick) begin
			baud_d = div_q;
		end else begin
			baud_d = baud_q - 12'h001;
		end
		tp_d = tp_q;
		if (tick) begin
			tp_d = (tp_q == 4'h0) ? tx_top : tp_q - 4'h1;
		end
		// Idle at the polarity level outside master mode
		xm_d = master ? (xm_q ^ tick) : cfg_q.clock_polarity;
	end

	// Slave pin sampling: first stage feeds only the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			baud_q <= DIV_RST;
			tp_q <= 4'h0;
			xm_q <= 1'b0;
			xs1_q <= 1'b0;
			xs2_q <= 1'b0;
			xs3_q <= 1'b0;
		end else begin
			baud_q <= baud_d;
			tp_q <= tp_d;
			xm_q <= xm_d;
			xs1_q <= xck_i;
			xs2_q <= xs1_q;
			xs3_q <= xs2_q;
		end
	end

	// Transmit frame sequencer, one step per bit time
	always_comb begin
		logic go;
		logic fin;
		go = 1'b0;
		fin = 1'b0;
		tst_d = tst_q;
		tsh_d = tsh_q;
		tcnt_d = tcnt_q;
		tpar_d = tpar_q;
		tx_load = 1'b0;
		tx_done = 1'b0;
		if (tx_step) begin
			case (tst_q)
				TX_IDLE: go = tfull_q & cfg_q.tx_en;
				TX_START: begin
					tst_d = TX_DATA;
					tcnt_d = 4'h0;
				end
				TX_DATA: begin
					tsh_d = tsh_q >> 1;
					tcnt_d = tcnt_q + 4'h1;
					if (tcnt_q == nb - 4'h1) begin
						tst_d = par_en ? TX_PAR : TX_STOP1;
					end
				end
				TX_PAR: tst_d = TX_STOP1;
				TX_STOP1: begin
					if (cfg_q.stop_bit_select) begin
						tst_d = TX_STOP2;
					end else begin
						fin = 1'b1;
					end
				end
				TX_STOP2: fin = 1'b1;
				default: tst_d = TX_IDLE;
			endcase
		end
		// Next frame starts straight after the last stop bit
		if (fin) begin
			if (tfull_q & cfg_q.tx_en) begin
				go = 1'b1;
			end else begin
				tst_d = TX_IDLE;
				tx_done = 1'b1;
			end
		end
		if (go) begin
			tst_d = TX_START;
			tx_load = 1'b1;
			tsh_d = tbuf_q;
			tpar_d = par_calc(tbuf_q, nb, par_odd);
		end
		// Line level follows the state entered at this edge
		case (tst_d)
			TX_START: txd_d = 1'b0;
			TX_DATA: txd_d = tsh_d[0];
			TX_PAR: txd_d = tpar_d;
			default: txd_d = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tst_q <= TX_IDLE;
			tsh_q <= 9'h000;
			tcnt_q <= 4'h0;
			tpar_q <= 1'b0;
			txd_q <= 1'b1;
		end else begin
			tst_q <= tst_d;
			tsh_q <= tsh_d;
			tcnt_q <= tcnt_d;
			tpar_q <= tpar_d;
			txd_q <= txd_d;
		end
	end
	assign txd_o = txd_q;

	// Receive recovery: mid-bit sampling async, clock-edge sampling sync
	always_comb begin
		logic [CHR_W-1:0] al;
		al = rsh_q >> (4'd9 - nb);
		rst_d = rst_q;
		rsh_d = rsh_q;
		rxdat_d = rxdat_q;
		rcnt_d = rcnt_q;
		roc_d = roc_q;
		rpar_d = rpar_q;
		fe_d = fe_q;
		pe_d = pe_q;
		rx_done = 1'b0;
		if (!cfg_q.rx_en) begin
			rst_d = RX_IDLE;
		end else if (rx_tick) begin
			case (rst_q)
				RX_IDLE: begin
					if (!rxd_i) begin
						rst_d = sync ? RX_DATA : RX_START;
						roc_d = 4'h0;
						rcnt_d = 4'h0;
					end
				end
				RX_START: begin
					// A start bit gone high by mid-bit was noise
					if (roc_q == (rx_top >> 1)) begin
						roc_d = 4'h0;
						rst_d = rxd_i ? RX_IDLE : RX_DATA;
					end else begin
						roc_d = roc_q + 4'h1;
					end
				end
				RX_DATA: begin
					if (roc_q == rx_top) begin
						roc_d = 4'h0;
						rsh_d = {rxd_i, rsh_q[8:1]};
						rcnt_d = rcnt_q + 4'h1;
						if (rcnt_q == nb - 4'h1) begin
							rst_d = par_en ? RX_PAR : RX_STOP;
						end
					end else begin
						roc_d = roc_q + 4'h1;
					end
				end
				RX_PAR: begin
					if (roc_q == rx_top) begin
						roc_d = 4'h0;
						rpar_d = rxd_i;
						rst_d = RX_STOP;
					end else begin
						roc_d = roc_q + 4'h1;
					end
				end
				RX_STOP: begin
					// Only the first stop bit is looked at
					if (roc_q == rx_top) begin
						roc_d = 4'h0;
						rst_d = RX_IDLE;
						rx_done = 1'b1;
						rxdat_d = al;
						fe_d = ~rxd_i;
						pe_d = par_en & (rpar_q != par_calc(al, nb, par_odd));
					end else begin
						roc_d = roc_q + 4'h1;
					end
				end
				default: rst_d = RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rst_q <= RX_IDLE;
			rsh_q <= 9'h000;
			rxdat_q <= 9'h000;
			rcnt_q <= 4'h0;
			roc_q <= 4'h0;
			rpar_q <= 1'b0;
			fe_q <= 1'b0;
			pe_q <= 1'b0;
		end else begin
			rst_q <= rst_d;
			rsh_q <= rsh_d;
			rxdat_q <= rxdat_d;
			rcnt_q <= rcnt_d;
			roc_q <= roc_d;
			rpar_q <= rpar_d;
			fe_q <= fe_d;
			pe_q <= pe_d;
		end
	end

	// Checks on the clock generator and framing
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_pin_rise;
		slave && $rose(xck_i) ##1 slave && xck_i;
	endsequence
	sequence s_tx_start_end;
		tst_q == TX_START && tx_step;
	endsequence
	sequence s_stop_low;
		rst_q == RX_STOP && cfg_q.rx_en && rx_tick && roc_q == rx_top && !rxd_i;
	endsequence

	baud_reload_a: assert property (lo_wr |=>
		baud_q == {div_q[11:8], $past(avs_writedata_i[7:0])})
		else $error("baud counter not reloaded on low byte write");
	baud_tick_a: assert property (tick && !lo_wr |=> baud_q == $past(div_q))
		else $error("baud counter not reloaded at zero");
	tx_divide_a: assert property (!sync && tx_step |=> !tx_step [*7])
		else $error("transmit step faster than eight ticks");
	sync_ds_a: assert property (sync |-> rx_top == TOP_SYNC && !u2x)
		else $error("double speed active in sync mode");
	async_ds_a: assert property (!sync && cfg_q.double_speed |->
		rx_top == TOP_DBL && tx_top == TOP_DBL)
		else $error("double speed does not halve samples");
	slave_edge_a: assert property (s_pin_rise |=> rise)
		else $error("slave clock edge not seen two clocks later");
	master_clk_a: assert property (master |=>
		(xck_o != $past(xck_o)) == $past(tick) && !xck_oe_n_o)
		else $error("master clock pin not driven from ticks");
	// Polarity taken from the event cycle; a control write may land on the same edge
	change_edge_a: assert property (master && chg_ev |=>
		xck_o == !$past(cfg_q.clock_polarity))
		else $error("data change on wrong clock edge");
	sample_edge_a: assert property (master && smp_ev |=>
		xck_o == $past(cfg_q.clock_polarity))
		else $error("sample on wrong clock edge");
	start_stop_a: assert property ((tst_q == TX_START |-> !txd_o) and
		(tst_q inside {TX_STOP1, TX_STOP2, TX_IDLE} |-> txd_o))
		else $error("start or stop level wrong");
	lsb_first_a: assert property (s_tx_start_end |=> txd_o == $past(tsh_q[0]))
		else $error("first data bit is not the LSB");
	tx_parity_a: assert property (tx_load |=>
		tpar_q == par_calc($past(tbuf_q), $past(nb), $past(par_odd)))
		else $error("transmit parity wrong");
	frame_err_a: assert property (s_stop_low |=> fe_q && rxc_q)
		else $error("zero first stop bit not flagged");
endmodule // ucf_core

// ---- src/ucf_pkg.sv ----
// Constants, register map, config/status layouts and state codes of the serial clock/frame block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one system clock.
package ucf_pkg;
	// Bus geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [4:0] OFS_DIV_LO = 5'h00;
	localparam logic [4:0] OFS_DIV_HI = 5'h04;
	localparam logic [4:0] OFS_CTRL = 5'h08;
	localparam logic [4:0] OFS_STAT = 5'h0c;
	localparam logic [4:0] OFS_DATA = 5'h10;
	// Divisor and character geometry
	localparam int DIV_W = 12;
	localparam int CHR_W = 9;
	localparam int CFG_W = 13;
	localparam int STAT_W = 6;
	localparam logic [11:0] DIV_RST = 12'h000;
	// Reset config: asynchronous, 8 data bits, no parity, one stop bit
	localparam logic [12:0] CFG_RST = 13'h0030;
	localparam int STAT_TXC = 0;
	localparam logic [2:0] CS_NINE = 3'h7;
	// Recovery state counts minus one: 16, 8 and 1 (sync uses clock edges)
	localparam logic [3:0] TOP_NORM = 4'hf;
	localparam logic [3:0] TOP_DBL = 4'h7;
	localparam logic [3:0] TOP_SYNC = 4'h0;

	// Control register layout, bit 12 first from the top
	typedef struct packed {
		logic rx_en;
		logic tx_en;
		logic tx_bit8;
		logic stop_bit_select;
		logic [1:0] parity_mode;
		logic [2:0] char_size;
		logic clock_polarity;
		logic ext_clock_pin_direction;
		logic double_speed;
		logic sync_mode_select;
	} ucf_cfg_s;

	// Status register layout
	typedef struct packed {
		logic rx_bit8;
		logic parity_error;
		logic frame_error;
		logic busy;
		logic rx_complete_flag;
		logic tx_complete_flag;
	} ucf_stat_s;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_DATA = 3'b010,
		TX_PAR = 3'b011,
		TX_STOP1 = 3'b100,
		TX_STOP2 = 3'b101
	} ucf_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PAR = 3'b011,
		RX_STOP = 3'b100
	} ucf_rx_e;
endpackage

// ---- tb/ucf_remote.sv ----
// Remote serial device: samples the transmit line, drives the receive line and,
// as synchronous master, makes the transfer clock. Assumes the shared system clock.
`timescale 1ns/100ps
module ucf_remote (
	input wire logic clk_i,
	input wire logic txd_i,
	input wire logic xck_i,
	output logic rxd_o,
	output logic xck_o
);
	logic run_q;
	logic idle_lvl;
	int cnt;

	// Line idles high, own clock parked until a frame is fetched
	initial begin
		rxd_o = 1'b1;
		xck_o = 1'b0;
		run_q = 1'b0;
		idle_lvl = 1'b0;
		cnt = 0;
	end

	// Half period of 6 clocks keeps the clock well under a quarter of the system rate
	always @(posedge clk_i) begin
		if (!run_q || cnt == 5) begin
			cnt <= 0;
			xck_o <= run_q ? !xck_o : idle_lvl;
		end else begin
			cnt <= cnt + 1;
		end
	end

	// Async frame onto the receive line, bit 0 first, then back to idle
	task automatic send(input logic [12:0] v, input int nb, input int bitclk);
		for (int i = 0; i < nb; i++) begin
			rxd_o <= v[i];
			repeat (bitclk) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
	endtask

	// Fetch one frame from the transmit line; lag counts clocks spent waiting for start in async mode and stays 0 in sync
	task automatic grab(input int nb, input int bitclk, input logic sync, input logic pol,
		output logic [12:0] v, output int lag);
		lag = 0;
		v = '0;
		if (sync) begin
			run_q <= 1'b1;
			for (int i = 0; i < nb; i++) begin
				do begin
					if (pol) @(posedge xck_i); else @(negedge xck_i);
				end while (i == 0 && txd_i !== 1'b0);
				v[i] = txd_i;
			end
			// One more period so the last stop bit can finish
			@(posedge xck_i);
			@(negedge xck_i);
			run_q <= 1'b0;
		end else begin
			while (txd_i !== 1'b0) begin
				@(posedge clk_i);
				lag++;
			end
			repeat (bitclk / 2) @(posedge clk_i);
			for (int i = 0; i < nb; i++) begin
				if (i > 0) repeat (bitclk) @(posedge clk_i);
				v[i] = txd_i;
			end
		end
	endtask
endmodule // ucf_remote

// ---- tb/tb.sv ----
// Self-checking bench: registers, all frame formats, receive flags, synchronous roles.
// Assumes the remote model on the far side; the shared clock pin is resolved here.
`timescale 1ns/100ps
module tb;
	import ucf_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] be = 4'hf;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic waitreq;
	logic rxd;
	logic txd;
	logic xck_pin;
	logic dut_xck;
	logic xck_oe_n;
	logic part_xck;
	int n_mismatch = 0;
	int samples_checked = 0;
	int seed = 83524;
	ucf_cfg_s cfg;

	ucf_core dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .rxd_i(rxd), .txd_o(txd),
		.xck_i(xck_pin), .xck_o(dut_xck), .xck_oe_n_o(xck_oe_n));
	ucf_remote far (.clk_i(clk_i), .txd_i(txd), .xck_i(xck_pin), .rxd_o(rxd),
		.xck_o(part_xck));

	// Shared clock pin: the block drives it while its enable is low
	assign xck_pin = xck_oe_n ? part_xck : dut_xck;

	always #5 clk_i = !clk_i;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One bus cycle, held until waitrequest is seen low at an edge; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk_i);
		end while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	// High part first: the low write reloads the counter with both halves
	task automatic set_div(input logic [11:0] v);
		logic [31:0] q;
		bus(1'b1, OFS_DIV_HI, {28'h0, v[11:8]}, q);
		bus(1'b1, OFS_DIV_LO, {24'h0, v[7:0]}, q);
	endtask

	task automatic set_cfg();
		logic [31:0] q;
		bus(1'b1, OFS_CTRL, {19'h0, cfg}, q);
	endtask

	// Expected line bits, start first; bits above n are don't-care ones
	function automatic logic [12:0] exp_frame(input logic [8:0] d, input int nd,
		input logic [1:0] pm, input logic sb, output int n);
		logic [12:0] v;
		v = '1;
		v[0] = 1'b0;
		for (int i = 0; i < nd; i++) v[i + 1] = d[i];
		n = nd + 2 + int'(sb);
		if (pm[1]) begin
			v[nd + 1] = ^(d & ((9'h1 << nd) - 9'h1)) ^ pm[0];
			n++;
		end
		return v;
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		repeat (90000) @(posedge clk_i);
		n_mismatch++;
		stop_test();
	end

	initial begin
		logic [31:0] q;
		logic [8:0] d;
		logic [8:0] d2;
		logic [12:0] v;
		logic [12:0] e;
		logic [2:0] cs;
		logic [1:0] pm;
		logic p;
		int nd;
		int nb;
		int bitclk;
		int lag;
		int tog;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("txd_idle", txd, 1'b1);
		chk("pin_released", xck_oe_n, 1'b1);
		// Reset values, unmapped place, divisor width, lane-gated write
		bus(1'b1, 5'h14, $random(seed), q);
		be <= 4'h0;
		bus(1'b1, OFS_CTRL, 32'h1fff, q);
		be <= 4'hf;
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 5'(i * 4), '0, q);
			chk("reset_value", q, (i == 2) ? {19'h0, CFG_RST} : 32'h0);
		end
		d = 9'($random(seed));
		e = 13'($random(seed));
		bus(1'b1, OFS_DIV_HI, {19'h0, e}, q);
		bus(1'b1, OFS_DIV_LO, {23'h0, d}, q);
		bus(1'b0, OFS_DIV_HI, '0, q);
		chk("div_high", q, {28'h0, e[3:0]});
		bus(1'b0, OFS_DIV_LO, '0, q);
		chk("div_low", q, {24'h0, d[7:0]});
		$display("test registers done");
		// All thirty formats, divisor and double speed varied
		for (int f = 0; f < 30; f++) begin
			cs = (f % 5 == 4) ? CS_NINE : 3'(f % 5);
			nd = (f % 5 == 4) ? 9 : f % 5 + 5;
			pm = (f / 5 % 3 == 0) ? 2'b00 : {1'b1, f / 5 % 3 == 2};
			d = 9'($random(seed));
			d2 = {d[8], 8'($random(seed))};
			bitclk = (f % 2 ? 8 : 16) * (f % 3 + 1);
			cfg = CFG_RST;
			cfg.double_speed = 1'(f % 2);
			cfg.char_size = cs;
			cfg.parity_mode = pm;
			cfg.stop_bit_select = 1'(f / 15);
			cfg.tx_bit8 = d[8];
			cfg.tx_en = 1'b1;
			set_div(12'(f % 3));
			set_cfg();
			bus(1'b1, OFS_DATA, {24'h0, d[7:0]}, q);
			if (f % 10 == 0) begin
				while (txd !== 1'b0) begin
					@(posedge clk_i);
				end
				bus(1'b1, OFS_DATA, {24'h0, d2[7:0]}, q);
			end
			e = exp_frame(d, nd, pm, cfg.stop_bit_select, nb);
			far.grab(nb, bitclk, 1'b0, 1'b0, v, lag);
			chk("tx_frame", v, e & ((13'h1 << nb) - 13'h1));
			if (f % 10 == 0) begin
				e = exp_frame(d2, nd, pm, cfg.stop_bit_select, nb);
				far.grab(nb, bitclk, 1'b0, 1'b0, v, lag);
				chk("b2b_frame", v, e & ((13'h1 << nb) - 13'h1));
				chk("b2b_gap", lag <= bitclk / 2 + 1, 1'b1);
			end
			repeat (bitclk) @(posedge clk_i);
			bus(1'b0, OFS_STAT, '0, q);
			chk("tx_done", q[STAT_TXC], 1'b1);
			bus(1'b1, OFS_STAT, 32'h1, q);
		end
		$display("test transmit formats done");
		// Received frames: clean, bad parity, bad first stop, bad second stop
		set_div(12'h000);
		cfg = CFG_RST;
		cfg.parity_mode = 2'b10;
		cfg.stop_bit_select = 1'b1;
		cfg.rx_en = 1'b1;
		set_cfg();
		for (int k = 0; k < 4; k++) begin
			d = 9'($random(seed)) & 9'h0ff;
			e = exp_frame(d, 8, 2'b10, 1'b1, nb);
			if (k == 1) e[9] = !e[9];
			if (k > 1) e[k + 8] = 1'b0;
			far.send(e, nb, 16);
			bus(1'b0, OFS_STAT, '0, q);
			chk("rx_flags", q[4:1], {k == 1, k == 2, 2'b01});
			bus(1'b0, OFS_DATA, '0, q);
			chk("rx_data", q[7:0], d[7:0]);
			repeat (200) @(posedge clk_i);
		end
		$display("test receive flags done");
		// Both synchronous roles under both clock polarities
		set_div(12'h001);
		for (int m = 0; m < 4; m++) begin
			cfg = CFG_RST;
			cfg.sync_mode_select = 1'b1;
			cfg.double_speed = 1'b0;
			cfg.ext_clock_pin_direction = 1'(m / 2);
			cfg.clock_polarity = 1'(m % 2);
			cfg.tx_en = 1'b1;
			far.idle_lvl <= cfg.clock_polarity;
			set_cfg();
			// The control write lands on this edge; look once it has settled
			@(posedge clk_i);
			chk("pin_enable", xck_oe_n, !cfg.ext_clock_pin_direction);
			if (m / 2 == 1) begin
				tog = 0;
				p = xck_pin;
				repeat (16) begin
					@(posedge clk_i);
					if (xck_pin !== p) tog++;
					p = xck_pin;
				end
				chk("xck_toggles", tog, 8);
			end
			d = 9'($random(seed)) & 9'h0ff;
			bus(1'b1, OFS_DATA, {23'h0, d}, q);
			far.grab(10, 0, 1'b1, cfg.clock_polarity, v, lag);
			e = exp_frame(d, 8, 2'b00, 1'b0, nb);
			chk("sync_frame", v, e & 13'h3ff);
			repeat (40) @(posedge clk_i);
		end
		$display("test synchronous done");
		stop_test();
	end
endmodule // tb
